// file: hw/srs_cfg.svh
// Timing counts, vector addresses and widths for the reset sequencer.
// Assumes clk_i is the internal precision oscillator at 40 MHz.
`ifndef SRS_CFG_SVH
`define SRS_CFG_SVH

// Clock rate in MHz
`define SRS_CLK_MHZ 40
// Oscillator start-up time in ns
`define SRS_OSC_STARTUP_NS 4000
// Start-up wait in clock cycles, least time so rounded up
`define SRS_STARTUP_CYC ((`SRS_OSC_STARTUP_NS * `SRS_CLK_MHZ + 999) / 1000)
// Normal reset hold in oscillator cycles
`define SRS_HOLD_CYC 66
// Reset hold with crystal enabled in oscillator cycles
`define SRS_XTAL_HOLD_CYC 5000
// Width of the shared sequencing counter
`define SRS_CNT_W 13
// Program memory address width and reset vector bytes
`define SRS_ADDR_W 16
`define SRS_VEC_HI_ADDR 16'h0002
`define SRS_VEC_LO_ADDR 16'h0003
// Reset values of the pin synchronisers
`define SRS_PIN_RST_VAL 1'h1
`define SRS_POR_RST_VAL 1'h0

`endif

// file: hw/srs_pkg.sv
// Types shared by the reset sequencer files.
// Assumes srs_cfg.svh for the numeric constants.
package srs_pkg;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_STARTUP = 3'b000,
    ST_HOLD = 3'b001,
    ST_PIN_WAIT = 3'b010,
    ST_FETCH_HI = 3'b011,
    ST_FETCH_LO = 3'b100,
    ST_LOAD_PC = 3'b101,
    ST_RUN = 3'b110
  } srs_state_t;

  // Kind of reset in progress
  typedef enum logic {
    KIND_SYS = 1'b0,
    KIND_STOP = 1'b1
  } srs_kind_t;

endpackage

// file: hw/srs_sync2.sv
// Two-flop synchroniser for asynchronous level inputs.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`include "srs_cfg.svh"

module srs_sync2 #(
  parameter int unsigned W = 2,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  // Next values: first flop feeds only the second
  always_comb begin
    meta_d = async_i;
    sync_d = meta_q;
  end

  // Register both stages
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_o = sync_q;

endmodule

// file: hw/srs_reset_seq.sv
// Reset and stop-mode recovery sequencer with reset vector fetch.
// Assumes clk_i is the internal precision oscillator and program memory
// returns data one cycle after the address.
`timescale 1ns/1ps
`include "srs_cfg.svh"

// Functional notes
// R1: Hold CPU and peripherals 66 oscillator cycles
// R2: Crystal option lengthens hold to 5000 cycles
// R3: Wait 4 us oscillator start-up first
// R4: Power-on delay counts from supply good
// R5: Stay in reset while pin asserted
// R6: GPIO inputs, pull-ups off at reset
// R7: CPU idle; crystal, watchdog oscillators run
// R8: Load defined register reset values
// R9: Fetch two-byte vector into program counter
// R10: System clock is internal oscillator after reset
// R11: Stop recovery reinitialises only clock registers
module srs_reset_seq #(
  parameter int unsigned XTAL_HOLD_CYC = `SRS_XTAL_HOLD_CYC
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic supply_ok_i,
  input wire logic ext_reset_b_i,
  input wire logic stop_recover_i,
  input wire logic xtal_opt_en_i,
  input wire logic [7:0] pmem_data_i,
  output logic [`SRS_ADDR_W-1:0] pmem_addr_o,
  output logic pmem_rd_o,
  output logic [`SRS_ADDR_W-1:0] pc_o,
  output logic pc_load_o,
  output logic cpu_reset_b_o,
  output logic periph_reset_b_o,
  output logic ctrl_reg_init_o,
  output logic clk_reg_init_o,
  output logic gpio_safe_o,
  output logic sysclk_ipo_sel_o,
  output logic xtal_run_o,
  output logic wdt_osc_run_o
);

  localparam logic [`SRS_CNT_W-1:0] STARTUP_LAST = `SRS_CNT_W'(`SRS_STARTUP_CYC - 1);
  localparam logic [`SRS_CNT_W-1:0] HOLD_LAST = `SRS_CNT_W'(`SRS_HOLD_CYC - 1);
  localparam logic [`SRS_CNT_W-1:0] XTAL_LAST = `SRS_CNT_W'(XTAL_HOLD_CYC - 1);

  srs_pkg::srs_state_t state_q;
  srs_pkg::srs_state_t state_d;
  srs_pkg::srs_kind_t kind_q;
  srs_pkg::srs_kind_t kind_d;
  logic [`SRS_CNT_W-1:0] cnt_q;
  logic [`SRS_CNT_W-1:0] cnt_d;
  logic [`SRS_CNT_W-1:0] last_q;
  logic [`SRS_CNT_W-1:0] last_d;
  logic [7:0] vec_hi_q;
  logic [7:0] vec_hi_d;
  logic [`SRS_ADDR_W-1:0] addr_q;
  logic [`SRS_ADDR_W-1:0] addr_d;
  logic [`SRS_ADDR_W-1:0] pc_q;
  logic [`SRS_ADDR_W-1:0] pc_d;
  logic pc_load_q;
  logic pc_load_d;
  logic rd_q;
  logic rd_d;
  logic [1:0] pins_sync;
  logic supply_ok;
  logic pin_released;
  logic sys_restart;
  logic stop_restart;
  logic out_of_reset;

  // Supply detector and reset pin come from outside the clock domain
  srs_sync2 #(
    .W(2),
    .RST_VAL({`SRS_POR_RST_VAL, `SRS_PIN_RST_VAL})
  ) u_sync (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .async_i({supply_ok_i, ext_reset_b_i}),
    .sync_o(pins_sync)
  );

  assign supply_ok = pins_sync[1];
  assign pin_released = pins_sync[0];

  // True once the sequencer has left reset
  function automatic logic is_running(input srs_pkg::srs_state_t st);
    is_running = (st == srs_pkg::ST_RUN);
  endfunction

  // Supply loss always restarts; a pin reset is taken from the vector fetch onward
  assign sys_restart = !supply_ok ||
                       (!pin_released && (state_q == srs_pkg::ST_FETCH_HI ||
                                          state_q == srs_pkg::ST_FETCH_LO ||
                                          state_q == srs_pkg::ST_LOAD_PC ||
                                          is_running(state_q)));
  // Stop recovery is only meaningful from run
  assign stop_restart = stop_recover_i && is_running(state_q);

  // Sequencer next state
  always_comb begin
    state_d = state_q;
    kind_d = kind_q;
    cnt_d = cnt_q;
    last_d = last_q;
    vec_hi_d = vec_hi_q;
    addr_d = addr_q;
    pc_d = pc_q;
    pc_load_d = 1'b0;
    rd_d = 1'b0;
    if (sys_restart) begin
      // R4: count from supply good
      state_d = srs_pkg::ST_STARTUP;
      kind_d = srs_pkg::KIND_SYS;
      cnt_d = '0;
    end else if (stop_restart) begin
      state_d = srs_pkg::ST_STARTUP;
      kind_d = srs_pkg::KIND_STOP;
      cnt_d = '0;
    end else begin
      case (state_q)
        srs_pkg::ST_STARTUP: begin
          // R3: oscillator start-up wait
          // R2: pick hold length from option
          last_d = xtal_opt_en_i ? XTAL_LAST : HOLD_LAST;
          if (cnt_q == STARTUP_LAST) begin
            state_d = srs_pkg::ST_HOLD;
            cnt_d = '0;
          end else begin
            cnt_d = cnt_q + `SRS_CNT_W'(1);
          end
        end
        srs_pkg::ST_HOLD: begin
          // R1, R2: hold count latched during start-up
          if (cnt_q == last_q) begin
            state_d = srs_pkg::ST_PIN_WAIT;
            cnt_d = '0;
          end else begin
            cnt_d = cnt_q + `SRS_CNT_W'(1);
          end
        end
        srs_pkg::ST_PIN_WAIT: begin
          // R5: extend while pin held
          if (pin_released) begin
            state_d = srs_pkg::ST_FETCH_HI;
            addr_d = `SRS_VEC_HI_ADDR;
            rd_d = 1'b1;
          end
        end
        srs_pkg::ST_FETCH_HI: begin
          // R9: high byte comes from the even address
          state_d = srs_pkg::ST_FETCH_LO;
          addr_d = `SRS_VEC_LO_ADDR;
          rd_d = 1'b1;
        end
        srs_pkg::ST_FETCH_LO: begin
          vec_hi_d = pmem_data_i;
          state_d = srs_pkg::ST_LOAD_PC;
        end
        srs_pkg::ST_LOAD_PC: begin
          // R9: vector into program counter
          pc_d = {vec_hi_q, pmem_data_i};
          pc_load_d = 1'b1;
          state_d = srs_pkg::ST_RUN;
        end
        srs_pkg::ST_RUN: begin
          state_d = srs_pkg::ST_RUN;
        end
        default: begin
          state_d = srs_pkg::ST_STARTUP;
          kind_d = srs_pkg::KIND_SYS;
          cnt_d = '0;
        end
      endcase
    end
  end

  // Sequencer registers
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      state_q <= srs_pkg::ST_STARTUP;
      kind_q <= srs_pkg::KIND_SYS;
      cnt_q <= '0;
      last_q <= HOLD_LAST;
      vec_hi_q <= 8'h00;
      addr_q <= '0;
      pc_q <= '0;
      pc_load_q <= 1'b0;
      rd_q <= 1'b0;
    end else begin
      state_q <= state_d;
      kind_q <= kind_d;
      cnt_q <= cnt_d;
      last_q <= last_d;
      vec_hi_q <= vec_hi_d;
      addr_q <= addr_d;
      pc_q <= pc_d;
      pc_load_q <= pc_load_d;
      rd_q <= rd_d;
    end
  end

  assign out_of_reset = is_running(state_q);

  // R7: CPU and peripherals idle until run
  assign cpu_reset_b_o = out_of_reset;
  assign periph_reset_b_o = out_of_reset;
  // R8: reset values loaded only by a system reset
  assign ctrl_reg_init_o = !out_of_reset && (kind_q == srs_pkg::KIND_SYS);
  // R11: clock registers reinitialised by either kind
  assign clk_reg_init_o = !out_of_reset;
  // R6: safe GPIO from the start of reset
  assign gpio_safe_o = !out_of_reset;
  // R10: internal oscillator selected while clock registers reinitialise
  assign sysclk_ipo_sel_o = !out_of_reset;
  // R7: oscillators keep running through reset
  assign xtal_run_o = 1'b1;
  assign wdt_osc_run_o = 1'b1;
  assign pmem_addr_o = addr_q;
  assign pmem_rd_o = rd_q;
  assign pc_o = pc_q;
  assign pc_load_o = pc_load_q;

  // Checks
  a_hold_short_exit: assert property ( // R1
    @(posedge clk_i) disable iff (!rst_b_i)
    (state_q == srs_pkg::ST_HOLD && last_q == HOLD_LAST && cnt_q == HOLD_LAST && !sys_restart)
    |=> state_q == srs_pkg::ST_PIN_WAIT)
    else $error("hold did not end after normal count");

  a_hold_no_early: assert property ( // R1
    @(posedge clk_i) disable iff (!rst_b_i)
    (state_q == srs_pkg::ST_HOLD && cnt_q != last_q && !sys_restart)
    |=> state_q == srs_pkg::ST_HOLD && cnt_q == $past(cnt_q) + `SRS_CNT_W'(1))
    else $error("hold left early or count skipped");

  a_xtal_long_hold: assert property ( // R2
    @(posedge clk_i) disable iff (!rst_b_i)
    (state_q == srs_pkg::ST_STARTUP && cnt_q == STARTUP_LAST && supply_ok && !sys_restart)
    |=> last_q == ($past(xtal_opt_en_i) ? XTAL_LAST : HOLD_LAST))
    else $error("hold length does not follow crystal option");

  a_startup_wait: assert property ( // R3
    @(posedge clk_i) disable iff (!rst_b_i)
    ($rose(state_q == srs_pkg::ST_HOLD))
    |-> $past(cnt_q) == STARTUP_LAST && cnt_q == '0)
    else $error("hold entered before start-up time");

  a_por_restart: assert property ( // R4
    @(posedge clk_i) disable iff (!rst_b_i)
    !supply_ok |=> state_q == srs_pkg::ST_STARTUP && cnt_q == '0 && !cpu_reset_b_o)
    else $error("count not restarted while supply low");

  a_pin_extend: assert property ( // R5
    @(posedge clk_i) disable iff (!rst_b_i)
    (state_q == srs_pkg::ST_PIN_WAIT && !pin_released && supply_ok)
    |=> state_q == srs_pkg::ST_PIN_WAIT && !cpu_reset_b_o)
    else $error("reset released while pin asserted");

  a_gpio_safe: assert property ( // R6
    @(posedge clk_i) disable iff (!rst_b_i)
    !cpu_reset_b_o |-> gpio_safe_o && !periph_reset_b_o)
    else $error("GPIO not safe during reset");

  a_osc_running: assert property ( // R7
    @(posedge clk_i) disable iff (!rst_b_i)
    !cpu_reset_b_o |-> xtal_run_o && wdt_osc_run_o)
    else $error("oscillator stopped during reset");

  a_vector_fetch: assert property ( // R9
    @(posedge clk_i) disable iff (!rst_b_i)
    (state_q == srs_pkg::ST_PIN_WAIT && pin_released && supply_ok)
    |=> pmem_addr_o == `SRS_VEC_HI_ADDR && pmem_rd_o
    ##1 pmem_addr_o == `SRS_VEC_LO_ADDR && pmem_rd_o ##2 pc_load_o && cpu_reset_b_o)
    else $error("reset vector fetch sequence wrong");

  a_pc_value: assert property ( // R9
    @(posedge clk_i) disable iff (!rst_b_i)
    pc_load_o |-> pc_o == {$past(pmem_data_i, 2), $past(pmem_data_i, 1)})
    else $error("program counter not loaded with vector");

  a_clock_select: assert property ( // R10
    @(posedge clk_i) disable iff (!rst_b_i)
    $rose(cpu_reset_b_o) |-> $past(sysclk_ipo_sel_o) && !sysclk_ipo_sel_o)
    else $error("internal oscillator not selected through reset");

  a_stop_keeps_regs: assert property ( // R11
    @(posedge clk_i) disable iff (!rst_b_i)
    (stop_restart && !sys_restart)
    |=> !ctrl_reg_init_o && clk_reg_init_o && !cpu_reset_b_o)
    else $error("stop recovery touched general registers");

endmodule

// file: sim/srs_pmem_model.sv
// Program memory model answering the reset vector fetch.
// Assumes one-cycle read latency and a bench that sets the vector word.
`timescale 1ns/1ps
`include "srs_cfg.svh"

module srs_pmem_model (
  input wire logic clk_i,
  input wire logic [15:0] vec_i,
  input wire logic [`SRS_ADDR_W-1:0] pmem_addr_i,
  input wire logic pmem_rd_i,
  output logic [7:0] pmem_data_o
);
  // Addresses read, in order, for the bench to inspect
  logic [`SRS_ADDR_W-1:0] rd_log[$];

  initial pmem_data_o = 8'hA5;

  // vector byte order
  // High byte at the even address; idle data toggles so stale bytes never pass
  always @(posedge clk_i) begin
    if (pmem_rd_i === 1'b1) begin
      rd_log.push_back(pmem_addr_i);
      case (pmem_addr_i)
        16'h0002: pmem_data_o <= vec_i[15:8];
        16'h0003: pmem_data_o <= vec_i[7:0];
        default: pmem_data_o <= ~pmem_data_o;
      endcase
    end else begin
      pmem_data_o <= ~pmem_data_o;
    end
  end
endmodule

// file: sim/testbench.sv
// Self-checking bench for the reset sequencer.
// Assumes clk_i is the oscillator and a program memory model on the fetch port.
`timescale 1ns/1ps
`include "srs_cfg.svh"

module testbench;
  localparam int XHOLD = 200;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic supply_ok_i = 1'b0;
  logic ext_reset_b_i = 1'b1;
  logic stop_recover_i = 1'b0;
  logic xtal_opt_en_i = 1'b0;
  logic [15:0] vec = 16'h0000;
  logic [7:0] pmem_data_i;
  logic [`SRS_ADDR_W-1:0] pmem_addr_o;
  logic [`SRS_ADDR_W-1:0] pc_o;
  logic pmem_rd_o, pc_load_o, cpu_reset_b_o, periph_reset_b_o, ctrl_reg_init_o;
  logic clk_reg_init_o, gpio_safe_o, sysclk_ipo_sel_o, xtal_run_o, wdt_osc_run_o;
  int failures = 0;
  int n_checks = 0;
  int cycles = 0;
  int n_sys;
  int n;

  srs_reset_seq #(.XTAL_HOLD_CYC(XHOLD)) dut (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .supply_ok_i(supply_ok_i), .ext_reset_b_i(ext_reset_b_i),
    .stop_recover_i(stop_recover_i), .xtal_opt_en_i(xtal_opt_en_i),
    .pmem_data_i(pmem_data_i), .pmem_addr_o(pmem_addr_o), .pmem_rd_o(pmem_rd_o),
    .pc_o(pc_o), .pc_load_o(pc_load_o), .cpu_reset_b_o(cpu_reset_b_o),
    .periph_reset_b_o(periph_reset_b_o), .ctrl_reg_init_o(ctrl_reg_init_o),
    .clk_reg_init_o(clk_reg_init_o), .gpio_safe_o(gpio_safe_o),
    .sysclk_ipo_sel_o(sysclk_ipo_sel_o), .xtal_run_o(xtal_run_o),
    .wdt_osc_run_o(wdt_osc_run_o));

  srs_pmem_model mem (.clk_i(clk_i), .vec_i(vec), .pmem_addr_i(pmem_addr_o),
    .pmem_rd_i(pmem_rd_o), .pmem_data_o(pmem_data_i));

  // 40 MHz clock
  initial forever #12.5 clk_i = ~clk_i;

  task automatic complete_run();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Cuts a hung run short
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 6000) begin
      failures++;
      $display("Error timeout expected run end seen %0d cycles", cycles);
      complete_run();
    end
  end

  task automatic chk_bit(input string what, input logic exp, input logic got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_lat(input string what, input int exp, input int got, input int tol);
    n_checks++;
    if (got < exp - tol || got > exp + tol) begin
      failures++;
      $display("Error %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic tick();
    @(posedge clk_i);
    #2;
  endtask

  // Counts edges up to the vector load, checking reset outputs each cycle
  task automatic wait_run(input logic sys, output int cnt);
    cnt = 0;
    forever begin
      tick();
      cnt++;
      if (pc_load_o === 1'b1 || cnt > 8000) break;
      chk_bit("cpu_reset_b", 1'b0, cpu_reset_b_o);
      chk_bit("periph_reset_b", 1'b0, periph_reset_b_o);
      chk_bit("ctrl_reg_init", sys, ctrl_reg_init_o);
      chk_bit("clk_reg_init", 1'b1, clk_reg_init_o);
      chk_bit("gpio_safe", 1'b1, gpio_safe_o);
      chk_bit("sysclk_ipo_sel", 1'b1, sysclk_ipo_sel_o);
      chk_bit("osc_run", 1'b1, xtal_run_o & wdt_osc_run_o);
    end
  endtask

  // Checks the loaded vector and the fetch order, then picks a new vector
  task automatic chk_vector();
    chk_word("pc", vec, pc_o);
    chk_bit("cpu_reset_b_run", 1'b1, cpu_reset_b_o);
    chk_bit("gpio_safe_run", 1'b0, gpio_safe_o);
    chk_bit("periph_reset_b_run", 1'b1, periph_reset_b_o);
    chk_bit("ctrl_reg_init_run", 1'b0, ctrl_reg_init_o);
    chk_bit("clk_reg_init_run", 1'b0, clk_reg_init_o);
    chk_bit("sysclk_ipo_sel_run", 1'b0, sysclk_ipo_sel_o);
    chk_lat("rd_count", 2, mem.rd_log.size(), 0);
    chk_word("rd_addr_hi", 16'h0002, mem.rd_log[0]);
    chk_word("rd_addr_lo", 16'h0003, mem.rd_log[1]);
    mem.rd_log.delete();
    vec = 16'($urandom);
  endtask

  // Main sequence: power-up, stop recovery, pin extension, supply dips
  initial begin
    void'($urandom(32'hCAA839FC));
    vec = 16'($urandom);
    repeat (16) tick();
    rst_b_i = 1'b1;
    tick();
    supply_ok_i = 1'b1;
    wait_run(1'b1, n_sys);
    chk_lat("hold_latency", 233, n_sys, 2);
    chk_vector();
    repeat (3) tick();
    stop_recover_i = 1'b1;
    tick();
    stop_recover_i = 1'b0;
    wait_run(1'b0, n);
    chk_lat("stop_latency", 231, n, 2);
    chk_vector();
    ext_reset_b_i = 1'b0;
    repeat (4) tick();
    repeat (400) begin
      tick();
      chk_bit("cpu_reset_b_pin", 1'b0, cpu_reset_b_o);
    end
    ext_reset_b_i = 1'b1;
    wait_run(1'b1, n);
    chk_lat("pin_release", 7, n, 2);
    chk_vector();
    for (int k = 0; k < 2; k++) begin
      xtal_opt_en_i = k[0];
      supply_ok_i = 1'b0;
      repeat (4 + $urandom_range(7)) tick();
      chk_bit("cpu_reset_b_dip", 1'b0, cpu_reset_b_o);
      supply_ok_i = 1'b1;
      wait_run(1'b1, n);
      chk_lat("supply_latency", n_sys + k * (XHOLD - 66), n, 0);
      chk_vector();
    end
    complete_run();
  end
endmodule
